// ==== inc/ltw_cfg.svh ====
// Purpose: Constants for the logical test and wait execution block
// Assumes: 32-bit APB register bus, 50 MHz core clock
// Notes: Offsets are byte addresses
`ifndef LTW_CFG_SVH
`define LTW_CFG_SVH
`define LTW_OFF_CMD 12'h000
`define LTW_OFF_OPA 12'h004
`define LTW_OFF_OPB 12'h008
`define LTW_OFF_FLAGS 12'h00c
`define LTW_OFF_STAT 12'h010
`define LTW_OFF_RESULT 12'h014
`define LTW_OP_TEST_ACC8_IMM 8'ha8
`define LTW_OP_TEST_ACC16_IMM 8'ha9
`define LTW_OP_TEST_RM8_IMM 8'hf6
`define LTW_OP_TEST_RM16_IMM 8'hf7
`define LTW_OP_TEST_RM8_R8 8'h84
`define LTW_OP_TEST_RM16_R16 8'h85
`define LTW_OP_WAIT 8'h9b
`define LTW_OP_SUB_RM16_IMM8 8'h83
`define LTW_OP_SUB_RM16_R16 8'h29
`define LTW_OP_SUB_RM8_R8 8'h28
`define LTW_REG_TEST 3'h0
`define LTW_CLK_3 5'd3
`define LTW_CLK_4 5'd4
`define LTW_CLK_10 5'd10
`define LTW_CLK_14 5'd14
`define LTW_CLK_WAIT 5'd1
`define LTW_CLK_SUB 5'd4
`define LTW_FLAGS_RESET 16'h0002
`define LTW_FLAGS_WMASK 16'h0fd5
`define LTW_CARRY_BIT 0
`define LTW_PARITY_BIT 2
`define LTW_AUX_BIT 4
`define LTW_ZERO_BIT 6
`define LTW_SIGN_BIT 7
`define LTW_OVERFLOW_BIT 11
`endif

// ==== inc/ltw_pkg.sv ====
// Purpose: Types for the logical test and wait execution block
// Assumes: Constants come from ltw_cfg.svh
// Notes: None
package ltw_pkg;
	typedef enum logic [2:0] {
		LTW_IDLE = 3'b001,
		LTW_BUSY = 3'b010,
		LTW_DONE = 3'b100
	} ltw_state_type;
	typedef struct packed {
		logic word;
		logic test;
		logic sub;
		logic wait_op;
		logic illegal;
		logic [4:0] clocks;
	} ltw_dec_type;
endpackage : ltw_pkg

// ==== inc/ltw_alu_if.sv ====
// Purpose: Operand and flag path between sequencer and ALU
// Assumes: Single clock domain
// Notes: Purely combinational carrier
`timescale 1ns/1ns
`default_nettype none
interface ltw_alu_if;
	logic word;
	logic sub;
	logic [15:0] opa;
	logic [15:0] opb;
	logic [15:0] flags_in;
	logic [15:0] result;
	logic [15:0] flags_out;
	modport seq (output word, sub, opa, opb, flags_in, input result, flags_out);
	modport alu (input word, sub, opa, opb, flags_in, output result, flags_out);
endinterface : ltw_alu_if
`default_nettype wire

// ==== hdl/ltw_decode.sv ====
// Purpose: Decode opcode, reg field and operand kind into a class and length
// Assumes: Opcode byte, addressing reg field, memory flag and bus width given
// Notes: Unknown opcodes flagged illegal
`timescale 1ns/1ns
`default_nettype none
`include "ltw_cfg.svh"
module ltw_decode (
	// Instruction
	input wire logic [7:0] opcode_i,
	input wire logic [2:0] reg_field_i,
	input wire logic mem_i,
	input wire logic bus8_i,
	// Decoded class
	output ltw_pkg::ltw_dec_type dec_o
);
	always_comb
	begin
		dec_o = '0;
		dec_o.clocks = `LTW_CLK_3;
		case (opcode_i)
			`LTW_OP_TEST_ACC8_IMM:
			begin
				dec_o.test = 1'b1;
			end
			`LTW_OP_TEST_ACC16_IMM:
			begin
				dec_o.test = 1'b1;
				dec_o.word = 1'b1;
				dec_o.clocks = `LTW_CLK_4;
			end
			`LTW_OP_TEST_RM8_IMM, `LTW_OP_TEST_RM16_IMM:
			begin
				dec_o.word = opcode_i[0];
				dec_o.test = (reg_field_i == `LTW_REG_TEST);
				dec_o.illegal = (reg_field_i != `LTW_REG_TEST);
				dec_o.clocks = !mem_i ? `LTW_CLK_4 :
					(opcode_i[0] && bus8_i) ? `LTW_CLK_14 : `LTW_CLK_10;
			end
			`LTW_OP_TEST_RM8_R8, `LTW_OP_TEST_RM16_R16:
			begin
				dec_o.word = opcode_i[0];
				dec_o.test = 1'b1;
				dec_o.clocks = !mem_i ? `LTW_CLK_3 :
					(opcode_i[0] && bus8_i) ? `LTW_CLK_14 : `LTW_CLK_10;
			end
			`LTW_OP_WAIT:
			begin
				dec_o.wait_op = 1'b1;
				dec_o.clocks = `LTW_CLK_WAIT;
			end
			`LTW_OP_SUB_RM8_R8, `LTW_OP_SUB_RM16_R16, `LTW_OP_SUB_RM16_IMM8:
			begin
				dec_o.sub = 1'b1;
				dec_o.word = opcode_i != `LTW_OP_SUB_RM8_R8;
				dec_o.clocks = `LTW_CLK_SUB;
			end
			default:
			begin
				dec_o.illegal = 1'b1;
			end
		endcase
	end
endmodule : ltw_decode
`default_nettype wire

// ==== hdl/ltw_alu.sv ====
// Purpose: AND and subtract datapath with flag generation
// Assumes: Byte operands sit in the low bits
// Notes: AND result is never written back by the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "ltw_cfg.svh"
module ltw_alu (
	// Operand path
	ltw_alu_if.alu a
);
	logic [16:0] diff;
	logic [15:0] res;
	logic msb;
	logic cy;
	logic ov;
	always_comb
	begin
		diff = {1'b0, a.opa} - {1'b0, a.opb};
		cy = 1'b0;
		ov = 1'b0;
		if (a.sub)
		begin
			res = a.word ? diff[15:0] : {8'h00, diff[7:0]};
			cy = a.word ? diff[16] : (a.opa[7:0] < a.opb[7:0]);
			msb = a.word ? res[15] : res[7];
			ov = a.word ? ((a.opa[15] ^ a.opb[15]) & (a.opa[15] ^ res[15])) :
				((a.opa[7] ^ a.opb[7]) & (a.opa[7] ^ res[7]));
		end
		else
		begin
			res = a.opa & a.opb;
			if (!a.word)
				res[15:8] = 8'h00;
			msb = a.word ? res[15] : res[7];
		end
		a.result = res;
		a.flags_out = a.flags_in;
		a.flags_out[`LTW_CARRY_BIT] = cy;
		a.flags_out[`LTW_OVERFLOW_BIT] = ov;
		a.flags_out[`LTW_ZERO_BIT] = a.word ? (res == 16'h0000) : (res[7:0] == 8'h00);
		a.flags_out[`LTW_SIGN_BIT] = msb;
		a.flags_out[`LTW_PARITY_BIT] = ~^res[7:0];
		a.flags_out[`LTW_AUX_BIT] = a.sub ? (a.opa[3:0] < a.opb[3:0]) : 1'b0;
	end
endmodule : ltw_alu
`default_nettype wire

// ==== hdl/ltw_core.sv ====
// Purpose: APB-driven executor for test, wait and subtract flag behaviour
// Assumes: Software loads operands then writes the command register
// Notes: Results of test never reach operand storage
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ltw_cfg.svh"
module ltw_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Status
	output logic busy_o
);
	ltw_alu_if alu_bus ();
	ltw_pkg::ltw_dec_type dec;
	ltw_pkg::ltw_state_type state_q, state_d;
	logic [15:0] opa_q, opa_d;
	logic [15:0] opb_q, opb_d;
	logic [15:0] flags_q, flags_d;
	logic [15:0] result_q, result_d;
	logic [7:0] opcode_q, opcode_d;
	logic [2:0] regf_q, regf_d;
	logic mem_q, mem_d;
	logic bus8_q, bus8_d;
	logic illegal_q, illegal_d;
	logic [4:0] cnt_q, cnt_d;
	logic [31:0] rdata_q, rdata_d;
	logic setup;
	logic wr;
	logic cmd_wr;
	logic [15:0] opb_ext;

	assign setup = psel_i && !penable_i;
	assign wr = psel_i && penable_i && pwrite_i;
	assign cmd_wr = wr && (paddr_i == `LTW_OFF_CMD) && (state_q == ltw_pkg::LTW_IDLE);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !(paddr_i == `LTW_OFF_CMD ||
		paddr_i == `LTW_OFF_OPA || paddr_i == `LTW_OFF_OPB ||
		paddr_i == `LTW_OFF_FLAGS || paddr_i == `LTW_OFF_STAT ||
		paddr_i == `LTW_OFF_RESULT);
	assign prdata_o = rdata_q;
	assign busy_o = state_q != ltw_pkg::LTW_IDLE;

	ltw_decode u_dec (
		.opcode_i(opcode_q),
		.reg_field_i(regf_q),
		.mem_i(mem_q),
		.bus8_i(bus8_q),
		.dec_o(dec)
	);

	// Immediate byte widened with sign for word subtract
	assign opb_ext = (opcode_q == `LTW_OP_SUB_RM16_IMM8) ?
		{{8{opb_q[7]}}, opb_q[7:0]} : opb_q;
	assign alu_bus.word = dec.word;
	assign alu_bus.sub = dec.sub;
	assign alu_bus.opa = opa_q;
	assign alu_bus.opb = opb_ext;
	assign alu_bus.flags_in = flags_q;

	ltw_alu u_alu (
		.a(alu_bus.alu)
	);

	// Sequencer
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		flags_d = flags_q;
		result_d = result_q;
		illegal_d = illegal_q;
		case (state_q)
			ltw_pkg::LTW_IDLE:
			begin
				if (cmd_wr)
				begin
					state_d = ltw_pkg::LTW_BUSY;
					cnt_d = 5'd1;
				end
			end
			ltw_pkg::LTW_BUSY:
			begin
				// Wait counts only its own length, no external stall
				if (cnt_q >= dec.clocks)
					state_d = ltw_pkg::LTW_DONE;
				else
					cnt_d = cnt_q + 5'd1;
			end
			ltw_pkg::LTW_DONE:
			begin
				state_d = ltw_pkg::LTW_IDLE;
				illegal_d = dec.illegal;
				if (dec.test || dec.sub)
					flags_d = alu_bus.flags_out;
				if (dec.sub)
					result_d = alu_bus.result;
				// Wait leaves flags and result as they were
			end
			default:
			begin
				state_d = ltw_pkg::LTW_IDLE;
			end
		endcase
		if (wr && paddr_i == `LTW_OFF_FLAGS && state_q == ltw_pkg::LTW_IDLE)
			flags_d = (pwdata_i[15:0] & `LTW_FLAGS_WMASK) | `LTW_FLAGS_RESET;
	end

	// Register writes
	always_comb
	begin
		opa_d = opa_q;
		opb_d = opb_q;
		opcode_d = opcode_q;
		regf_d = regf_q;
		mem_d = mem_q;
		bus8_d = bus8_q;
		if (wr && state_q == ltw_pkg::LTW_IDLE)
		begin
			if (paddr_i == `LTW_OFF_OPA)
				opa_d = pwdata_i[15:0];
			if (paddr_i == `LTW_OFF_OPB)
				opb_d = pwdata_i[15:0];
			if (paddr_i == `LTW_OFF_CMD)
			begin
				opcode_d = pwdata_i[7:0];
				regf_d = pwdata_i[10:8];
				mem_d = pwdata_i[12];
				bus8_d = pwdata_i[13];
			end
		end
	end

	// Read data captured at setup
	always_comb
	begin
		rdata_d = rdata_q;
		if (setup && !pwrite_i)
		begin
			case (paddr_i)
				`LTW_OFF_CMD: rdata_d = {18'h0, bus8_q, mem_q, 1'b0, regf_q, opcode_q};
				`LTW_OFF_OPA: rdata_d = {16'h0, opa_q};
				`LTW_OFF_OPB: rdata_d = {16'h0, opb_q};
				`LTW_OFF_FLAGS: rdata_d = {16'h0, flags_q};
				`LTW_OFF_STAT: rdata_d = {23'h0, cnt_q, illegal_q, state_q};
				`LTW_OFF_RESULT: rdata_d = {16'h0, result_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= ltw_pkg::LTW_IDLE;
			cnt_q <= 5'd0;
			flags_q <= `LTW_FLAGS_RESET;
			result_q <= 16'h0000;
			illegal_q <= 1'b0;
			opa_q <= 16'h0000;
			opb_q <= 16'h0000;
			opcode_q <= 8'h00;
			regf_q <= 3'h0;
			mem_q <= 1'b0;
			bus8_q <= 1'b0;
			rdata_q <= 32'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			flags_q <= flags_d;
			result_q <= result_d;
			illegal_q <= illegal_d;
			opa_q <= opa_d;
			opb_q <= opb_d;
			opcode_q <= opcode_d;
			regf_q <= regf_d;
			mem_q <= mem_d;
			bus8_q <= bus8_d;
			rdata_q <= rdata_d;
		end
	end
endmodule : ltw_core
`default_nettype wire

// ==== tb/ltw_core_chk.sv ====
// Purpose: Port assertions for ltw_core
// Assumes: Zero-wait APB, busy_o high N+1 cycles
// Notes: Bound after endmodule
`timescale 1ns/1ns
`default_nettype none
module ltw_core_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Watched ports
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	logic wr, go, tst, tst_q, tst_d;
	logic [7:0] op;
	assign wr = psel_i & penable_i & pwrite_i & !busy_o;
	assign go = wr & (paddr_i == 12'h000);
	assign op = pwdata_i[7:0];
	assign tst = op inside {8'ha8, 8'ha9, 8'h84, 8'h85} ||
		(op inside {8'hf6, 8'hf7} && pwdata_i[10:8] == 3'h0);
	// Last accepted write was a test
	always_comb
	begin
		tst_d = tst_q;
		if (wr)
			tst_d = go & tst;
	end
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			tst_q <= 1'b0;
		else
			tst_q <= tst_d;
	end
	AST_A8: assert property (
		go && op == 8'ha8 |=> busy_o[*4] ##1 !busy_o) else $error("a8 length wrong");
	AST_A9: assert property (
		go && op == 8'ha9 |=> busy_o[*5] ##1 !busy_o) else $error("a9 length wrong");
	AST_F6: assert property (
		go && op == 8'hf6 && pwdata_i[12:8] == 5'h00 |=> busy_o[*5] ##1 !busy_o)
		else $error("f6 length wrong");
	AST_F7: assert property (
		go && op == 8'hf7 && pwdata_i[13:8] == 6'h30 |=> busy_o[*8] ##1 busy_o[*7] ##1 !busy_o)
		else $error("f7 length wrong");
	AST_84: assert property (
		go && op == 8'h84 && pwdata_i[12] |=> busy_o[*8] ##1 busy_o[*3] ##1 !busy_o)
		else $error("84 length wrong");
	AST_85: assert property (
		go && op == 8'h85 && !pwdata_i[12] |=> busy_o[*4] ##1 !busy_o)
		else $error("85 length wrong");
	AST_WAIT: assert property (
		go && op == 8'h9b |=> busy_o[*2] ##1 !busy_o) else $error("wait stalled");
	AST_OFCF: assert property (
		psel_i && penable_i && !pwrite_i && paddr_i == 12'h00c && tst_q && !busy_o
		&& !$past(busy_o) |-> prdata_o[11] == 1'b0 && prdata_o[0] == 1'b0)
		else $error("overflow or carry set after test");
endmodule : ltw_core_chk
bind ltw_core ltw_core_chk i_chk (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .busy_o);
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for ltw_core
// Assumes: Zero-wait APB slave, seed 60
// Notes: Expectations from bench functions
`timescale 1ns/1ns
`default_nettype none
`include "ltw_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk_i, nrst_i, psel_i, penable_i, pwrite_i, pslverr_o, pready_o, busy_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic [15:0] a, b, c, f, x;
	logic [7:0] op;
	logic [7:0] ops [6] = '{8'ha8, 8'ha9, 8'hf6, 8'hf7, 8'h84, 8'h85};
	logic mem, b8, err;
	int err_total, n_checks, cyc, n;
	ltw_core i_ltw_core (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .busy_o);
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_total++;
			summarize();
		end
	end
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= ad;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1)
			@(posedge clk_i);
		r = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic exec(input logic [31:0] cmd);
		apb(1'b1, `LTW_OFF_CMD, cmd);
		n = 0;
		#1;
		while (busy_o === 1'b1 && n < 40)
		begin
			n++;
			@(posedge clk_i);
			#1;
		end
	endtask : exec
	task automatic ld(input logic [15:0] v);
		f = (v & `LTW_FLAGS_WMASK) | `LTW_FLAGS_RESET;
		apb(1'b1, `LTW_OFF_FLAGS, {16'h0, f});
		apb(1'b1, `LTW_OFF_OPA, {16'h0, a});
		apb(1'b1, `LTW_OFF_OPB, {16'h0, b});
	endtask : ld
	function automatic logic [15:0] tflags(logic [7:0] o, logic [15:0] p, q, fi);
		logic w;
		logic [15:0] t;
		w = o inside {8'ha9, 8'hf7, 8'h85};
		t = w ? p & q : {8'h00, p[7:0] & q[7:0]};
		tflags = fi;
		tflags[`LTW_CARRY_BIT] = 1'b0;
		tflags[`LTW_OVERFLOW_BIT] = 1'b0;
		tflags[`LTW_AUX_BIT] = 1'b0;
		tflags[`LTW_ZERO_BIT] = t == 16'h0;
		tflags[`LTW_SIGN_BIT] = w ? t[15] : t[7];
		tflags[`LTW_PARITY_BIT] = ~^t[7:0];
	endfunction : tflags
	function automatic int clks(logic [7:0] o, logic m, logic e);
		case (o)
			8'ha8: clks = 3;
			8'ha9: clks = 4;
			8'hf6: clks = m ? 10 : 4;
			8'hf7: clks = m ? (e ? 14 : 10) : 4;
			8'h84: clks = m ? 10 : 3;
			default: clks = m ? (e ? 14 : 10) : 3;
		endcase
	endfunction : clks
	initial
	begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
		nrst_i = 1'b0;
		void'($urandom(60));
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		apb(1'b0, `LTW_OFF_FLAGS, 32'h0);
		`CHK("flags reset", 32'h2, r)
		for (int i = 0; i < 40; i++)
		begin
			op = ops[$urandom % 6];
			{mem, b8} = 2'($urandom);
			a = 16'($urandom);
			b = 16'($urandom);
			if (i == 0) {op, a, b} = {8'ha9, 32'h80008000};
			if (i == 1) {op, a, b} = {8'ha8, 32'h00ff0000};
			if (i == 2) {op, mem, b8} = {8'hf7, 2'b11};
			if (i == 3) {op, mem} = {8'h84, 1'b1};
			if (i == 4) {op, mem} = {8'hf6, 1'b0};
			if (i == 5) {op, mem} = {8'h85, 1'b0};
			ld(16'($urandom));
			apb(1'b0, `LTW_OFF_RESULT, 32'h0);
			x = r[15:0];
			exec({18'h0, b8, mem, 4'h0, op});
			`CHK("busy cycles", clks(op, mem, b8) + 1, n)
			apb(1'b0, `LTW_OFF_FLAGS, 32'h0);
			`CHK("test flags", {16'h0, tflags(op, a, b, f)}, r)
			apb(1'b0, `LTW_OFF_RESULT, 32'h0);
			`CHK("result kept", x, r[15:0])
		end
		ld(16'($urandom));
		exec(32'h9b);
		`CHK("wait cycles", 2, n)
		apb(1'b0, `LTW_OFF_FLAGS, 32'h0);
		`CHK("wait flags", {16'h0, f}, r)
		ld(16'hffff);
		exec(32'h3f6);
		apb(1'b0, `LTW_OFF_FLAGS, 32'h0);
		`CHK("illegal flags", {16'h0, f}, r)
		apb(1'b0, `LTW_OFF_STAT, 32'h0);
		`CHK("illegal stat", 4'h9, r[3:0])
		for (int i = 0; i < 8; i++)
		begin
			op = i[0] ? 8'h83 : (i[1] ? 8'h28 : 8'h29);
			a = (i < 2) ? 16'h0 : 16'($urandom);
			b = 16'($urandom);
			ld(16'($urandom));
			exec({24'h0, op});
			c = (op == 8'h83) ? {{8{b[7]}}, b[7:0]} : b;
			if (op == 8'h28) {a, c} = {8'h00, a[7:0], 8'h00, c[7:0]};
			x = (op == 8'h28) ? {8'h00, 8'(a - c)} : a - c;
			apb(1'b0, `LTW_OFF_RESULT, 32'h0);
			`CHK("sub result", x, r[15:0])
			apb(1'b0, `LTW_OFF_FLAGS, 32'h0);
			`CHK("borrow", {a < c, a[3:0] < c[3:0]}, {r[0], r[4]})
		end
		apb(1'b0, 12'h018, 32'h0);
		`CHK("unmapped", {1'b1, 32'h0}, {err, r})
		summarize();
	end
endmodule : tb
`default_nettype wire
